// [rtp_pkg.sv]
// Shared constants, register map and types of the retention and trigger-priority controller
package rtp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NTRIG = 16;
    localparam int NRES = 8;
    localparam int NSUB = 4;
    localparam int IDW = 4;
    localparam int ADDR_W = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DEST_MAP = 8'h08;
    localparam logic [7:0] OFF_RET_MASK = 8'h0C;
    localparam logic [7:0] OFF_LP_MASK = 8'h10;
    localparam logic [7:0] OFF_LINK_MAP = 8'h14;

    // Control register fields
    localparam int CTRL_DRIVE_BIT = 0;
    localparam int CTRL_SW_LOW_REQ = 3;
    localparam int CTRL_GPIO_RET = 5;
    localparam int CTRL_DDR_RET = 7;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_GPIO_RET = 2;
    localparam int STAT_DDR_RET = 3;
    localparam int STAT_DRIVE = 4;
    localparam int STAT_LAST_ID_LSB = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DEST_MAP_RST = 32'h9555_55FF;
    localparam logic [31:0] RET_MASK_RST = 32'h0000_0003;
    localparam logic [31:0] LP_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] LINK_MAP_RST = 32'h0804_0201;

    // Destination codes held two bits per trigger in the destination map
    localparam logic [1:0] DEST_STANDBY = 2'h0;
    localparam logic [1:0] DEST_ACTIVE = 2'h1;
    localparam logic [1:0] DEST_RETENTION = 2'h2;
    localparam logic [1:0] DEST_SAFE = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_ACTIVE,
        ST_RETENTION,
        ST_SAFE
    } rtp_state_t;

    typedef struct packed {
        logic valid;
        logic [IDW-1:0] id;
    } rtp_win_t;

endpackage : rtp_pkg

// [rtp_prio_arb.sv]
// Fixed-priority arbiter: lowest active index wins
module rtp_prio_arb #(
    parameter int N = rtp_pkg::NTRIG
) (
    input wire logic [N-1:0] req,
    output rtp_pkg::rtp_win_t win
);

    always_comb begin
        win = '0;
        // Scan downward so the lowest index is written last and wins
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                win.valid = 1'b1;
                win.id = rtp_pkg::IDW'(i);
            end
        end
    end

endmodule : rtp_prio_arb

// [rtp_retention_ctrl.sv]
// Power-state controller with retention handling, trigger arbitration and AXI4-Lite registers
//
// Implementation choices: the register offsets and the AXI4-Lite register port.

// How it works
// RULE1 - In retention only retention rails stay up, each on or low-power per its own setting.
// RULE2 - A subsystem linked to a rail that stays active in retention is kept enabled too.
// RULE3 - In retention the safety output drive bit is cleared and the drive pin goes low.
// RULE4 - Request bit 5 high when a retention trigger is taken selects GPIO retention.
// RULE5 - Request bit 7 high when a retention trigger is taken selects DDR retention.
// RULE6 - The host sets bits 5 and 7 before it causes any trigger leading to retention.
// RULE7 - An active higher-priority trigger blocks all lower ones and their sequences.
// RULE8 - Priority runs from immediate shutdown at id 0 down to request bit 3 at the last id.
// RULE9 - In standby every rail is off and the drive pin is forced low.
// RULE10 - Each cycle all triggers are weighed and only the lowest id may launch a transition.
module rtp_retention_ctrl #(
    parameter int NTRIG = rtp_pkg::NTRIG,
    parameter int NRES = rtp_pkg::NRES,
    parameter int NSUB = rtp_pkg::NSUB
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [rtp_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rtp_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NTRIG-2:0] ext_trig,
    output logic [NRES-1:0] rail_on,
    output logic [NRES-1:0] rail_lp,
    output logic [NSUB-1:0] subsys_en,
    output logic safety_output_drive_pin,
    output logic gpio_retention,
    output logic ddr_retention,
    output logic [1:0] power_state,
    output logic transition_launch,
    output logic [rtp_pkg::IDW-1:0] launch_id
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [rtp_pkg::ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [31:0] ctrl_ff, nxt_ctrl, dest_map_ff, nxt_dest_map;
    logic [31:0] ret_mask_ff, nxt_ret_mask, lp_mask_ff, nxt_lp_mask;
    logic [31:0] link_map_ff, nxt_link_map;
    rtp_pkg::rtp_state_t state_ff, nxt_state;
    logic gpio_ret_ff, nxt_gpio_ret, ddr_ret_ff, nxt_ddr_ret;
    logic launch_ff, nxt_launch;
    logic [rtp_pkg::IDW-1:0] launch_id_ff, nxt_launch_id;
    logic [NRES-1:0] rail_on_ff, nxt_rail_on, rail_lp_ff, nxt_rail_lp;
    logic [NSUB-1:0] subsys_ff, nxt_subsys;
    logic drive_pin_ff, nxt_drive_pin;

    logic [NTRIG-1:0] trig_req;
    rtp_pkg::rtp_win_t win;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = val[8*b +: 8];
            end
        end
        return res;
    endfunction : merge

    function automatic rtp_pkg::rtp_state_t dest_state(input logic [1:0] code);
        case (code)
            rtp_pkg::DEST_STANDBY: return rtp_pkg::ST_STANDBY;
            rtp_pkg::DEST_ACTIVE: return rtp_pkg::ST_ACTIVE;
            rtp_pkg::DEST_RETENTION: return rtp_pkg::ST_RETENTION;
            default: return rtp_pkg::ST_SAFE;
        endcase
    endfunction : dest_state

    function automatic logic [1:0] state_code(input rtp_pkg::rtp_state_t st);
        case (st)
            rtp_pkg::ST_STANDBY: return rtp_pkg::DEST_STANDBY;
            rtp_pkg::ST_ACTIVE: return rtp_pkg::DEST_ACTIVE;
            rtp_pkg::ST_RETENTION: return rtp_pkg::DEST_RETENTION;
            default: return rtp_pkg::DEST_SAFE;
        endcase
    endfunction : state_code

    ////////////////////////////////////////////////////////////////////////////////
    // Trigger arbitration
    // Last id is the host's low-priority request bit; pins carry ids 0 upward
    assign trig_req = {ctrl_ff[rtp_pkg::CTRL_SW_LOW_REQ], ext_trig}; // [RULE8]

    rtp_prio_arb #(
        .N(NTRIG)
    ) u_arb (
        .req(trig_req),
        .win(win)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        rtp_pkg::rtp_state_t tgt;
        logic [NRES-1:0] kept_active;
        tgt = dest_state(dest_map_ff[2*win.id +: 2]);
        kept_active = '0;
        nxt_aw_held = aw_held_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_held = w_held_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_arready = arready_ff;
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        nxt_ctrl = ctrl_ff;
        nxt_dest_map = dest_map_ff;
        nxt_ret_mask = ret_mask_ff;
        nxt_lp_mask = lp_mask_ff;
        nxt_link_map = link_map_ff;
        nxt_state = state_ff;
        nxt_gpio_ret = gpio_ret_ff;
        nxt_ddr_ret = ddr_ret_ff;
        nxt_launch = 1'b0;
        nxt_launch_id = launch_id_ff;

        // One winner per cycle; a winner already at its destination still blocks the rest
        if (win.valid && tgt != state_ff) begin // [RULE7] [RULE10]
            nxt_state = tgt;
            nxt_launch = 1'b1;
            nxt_launch_id = win.id;
            // Variant is fixed by the request bits as they stand when the trigger is taken
            nxt_gpio_ret = (tgt == rtp_pkg::ST_RETENTION) && ctrl_ff[rtp_pkg::CTRL_GPIO_RET]; // [RULE4]
            nxt_ddr_ret = (tgt == rtp_pkg::ST_RETENTION) && ctrl_ff[rtp_pkg::CTRL_DDR_RET]; // [RULE5]
        end

        // Write channel: address and data latched independently, committed together
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (aw_held_ff && w_held_ff && !bvalid_ff) begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = rtp_pkg::RESP_OKAY;
            case (awaddr_ff)
                rtp_pkg::OFF_CTRL: nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
                rtp_pkg::OFF_DEST_MAP: nxt_dest_map = merge(dest_map_ff, wdata_ff, wstrb_ff);
                rtp_pkg::OFF_RET_MASK: nxt_ret_mask = merge(ret_mask_ff, wdata_ff, wstrb_ff);
                rtp_pkg::OFF_LP_MASK: nxt_lp_mask = merge(lp_mask_ff, wdata_ff, wstrb_ff);
                rtp_pkg::OFF_LINK_MAP: nxt_link_map = merge(link_map_ff, wdata_ff, wstrb_ff);
                rtp_pkg::OFF_STATUS: nxt_bresp = rtp_pkg::RESP_OKAY;
                default: nxt_bresp = rtp_pkg::RESP_SLVERR;
            endcase
        end
        nxt_awready = !nxt_aw_held;
        nxt_wready = !nxt_w_held;

        // Read channel: one read in flight, answered the cycle after acceptance
        // Idle with nothing outstanding raises ready, which also brings it up after reset
        if (!arready_ff && !rvalid_ff) begin
            nxt_arready = 1'b1;
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
            nxt_arready = 1'b1;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_arready = 1'b0;
            nxt_rvalid = 1'b1;
            nxt_rresp = rtp_pkg::RESP_OKAY;
            nxt_rdata = '0;
            case (s_axi_araddr)
                rtp_pkg::OFF_CTRL: nxt_rdata = ctrl_ff;
                rtp_pkg::OFF_STATUS: begin
                    nxt_rdata[rtp_pkg::STAT_STATE_LSB +: 2] = state_code(state_ff);
                    nxt_rdata[rtp_pkg::STAT_GPIO_RET] = gpio_ret_ff;
                    nxt_rdata[rtp_pkg::STAT_DDR_RET] = ddr_ret_ff;
                    nxt_rdata[rtp_pkg::STAT_DRIVE] = drive_pin_ff;
                    nxt_rdata[rtp_pkg::STAT_LAST_ID_LSB +: rtp_pkg::IDW] = launch_id_ff;
                end
                rtp_pkg::OFF_DEST_MAP: nxt_rdata = dest_map_ff;
                rtp_pkg::OFF_RET_MASK: nxt_rdata = ret_mask_ff;
                rtp_pkg::OFF_LP_MASK: nxt_rdata = lp_mask_ff;
                rtp_pkg::OFF_LINK_MAP: nxt_rdata = link_map_ff;
                default: nxt_rresp = rtp_pkg::RESP_SLVERR;
            endcase
        end

        // Device clear beats a software set: the drive bit only lives in the active state
        if (nxt_state != rtp_pkg::ST_ACTIVE) begin
            nxt_ctrl[rtp_pkg::CTRL_DRIVE_BIT] = 1'b0; // [RULE3] [RULE9]
        end
        nxt_drive_pin = nxt_ctrl[rtp_pkg::CTRL_DRIVE_BIT] &&
                        (nxt_state == rtp_pkg::ST_ACTIVE); // [RULE3] [RULE9]

        // Rails and linked subsystems follow the state being entered
        nxt_subsys = '0;
        case (nxt_state)
            rtp_pkg::ST_ACTIVE: begin
                nxt_rail_on = '1;
                nxt_rail_lp = '0;
                nxt_subsys = '1;
            end
            rtp_pkg::ST_RETENTION: begin
                nxt_rail_on = ret_mask_ff[NRES-1:0] & ~lp_mask_ff[NRES-1:0]; // [RULE1]
                nxt_rail_lp = ret_mask_ff[NRES-1:0] & lp_mask_ff[NRES-1:0]; // [RULE1]
                kept_active = nxt_rail_on;
                for (int s = 0; s < NSUB; s++) begin
                    nxt_subsys[s] = |(link_map_ff[s*NRES +: NRES] & kept_active); // [RULE2]
                end
            end
            default: begin
                // Standby and safe states drop every rail
                nxt_rail_on = '0; // [RULE9]
                nxt_rail_lp = '0;
            end
        endcase
        if (nxt_state != rtp_pkg::ST_RETENTION) begin
            nxt_gpio_ret = 1'b0;
            nxt_ddr_ret = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= rtp_pkg::RESP_OKAY;
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= rtp_pkg::RESP_OKAY;
            ctrl_ff <= rtp_pkg::CTRL_RST;
            dest_map_ff <= rtp_pkg::DEST_MAP_RST;
            ret_mask_ff <= rtp_pkg::RET_MASK_RST;
            lp_mask_ff <= rtp_pkg::LP_MASK_RST;
            link_map_ff <= rtp_pkg::LINK_MAP_RST;
            state_ff <= rtp_pkg::ST_STANDBY;
            gpio_ret_ff <= 1'b0;
            ddr_ret_ff <= 1'b0;
            launch_ff <= 1'b0;
            launch_id_ff <= '0;
            rail_on_ff <= '0;
            rail_lp_ff <= '0;
            subsys_ff <= '0;
            drive_pin_ff <= 1'b0;
        end else begin
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            aw_held_ff <= nxt_aw_held;
            w_held_ff <= nxt_w_held;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb_ff <= nxt_wstrb;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            ctrl_ff <= nxt_ctrl;
            dest_map_ff <= nxt_dest_map;
            ret_mask_ff <= nxt_ret_mask;
            lp_mask_ff <= nxt_lp_mask;
            link_map_ff <= nxt_link_map;
            state_ff <= nxt_state;
            gpio_ret_ff <= nxt_gpio_ret;
            ddr_ret_ff <= nxt_ddr_ret;
            launch_ff <= nxt_launch;
            launch_id_ff <= nxt_launch_id;
            rail_on_ff <= nxt_rail_on;
            rail_lp_ff <= nxt_rail_lp;
            subsys_ff <= nxt_subsys;
            drive_pin_ff <= nxt_drive_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign rail_on = rail_on_ff;
    assign rail_lp = rail_lp_ff;
    assign subsys_en = subsys_ff;
    assign safety_output_drive_pin = drive_pin_ff;
    assign gpio_retention = gpio_ret_ff;
    assign ddr_retention = ddr_ret_ff;
    assign power_state = state_ff;
    assign transition_launch = launch_ff;
    assign launch_id = launch_id_ff;

endmodule : rtp_retention_ctrl

// [rtp_ret_sva.sv]
// Concurrent checks on the state, rail and launch outputs of the retention controller
module rtp_ret_sva #(
    parameter int NTRIG = 16,
    parameter int NRES = 8,
    parameter int NSUB = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NTRIG-2:0] ext_trig,
    input wire logic [NRES-1:0] rail_on,
    input wire logic [NRES-1:0] rail_lp,
    input wire logic [NSUB-1:0] subsys_en,
    input wire logic safety_output_drive_pin,
    input wire logic gpio_retention,
    input wire logic ddr_retention,
    input wire logic [1:0] power_state,
    input wire logic transition_launch,
    input wire logic [3:0] launch_id
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // One-hot of the launched id; the top bit stands for the software request, not a pin
    logic [NTRIG-1:0] sel;
    assign sel = NTRIG'(1) << launch_id;

    ////////////////////////////////////////////////////////////////////////////////
    drive_off_a: assert property (power_state != 2'h1 |->
        !safety_output_drive_pin) else $error("drive pin high outside active");
    standby_dark_a: assert property (power_state == 2'h0 |->
        rail_on == '0 && rail_lp == '0 && subsys_en == '0) else $error("rail up in standby");
    ret_mode_a: assert property (power_state == 2'h2 |-> (rail_on & rail_lp) == '0)
        else $error("rail both on and low power");
    link_rail_a: assert property (power_state == 2'h2 && rail_on == '0 |->
        subsys_en == '0) else $error("subsystem up without an active rail");
    variant_state_a: assert property (gpio_retention || ddr_retention |->
        power_state == 2'h2) else $error("retention variant outside retention");
    variant_hold_a: assert property (power_state == 2'h2 &&
        !transition_launch |-> $stable({gpio_retention, ddr_retention}))
        else $error("variant changed in retention");
    launch_move_a: assert property (transition_launch |->
        power_state != $past(power_state)) else $error("launch without a state change");
    move_launch_a: assert property (power_state != $past(power_state) |->
        transition_launch) else $error("state change without a launch");
    lowest_wins_a: assert property (transition_launch |->
        ({1'b1, $past(ext_trig)} & (sel | (sel - NTRIG'(1)))) == sel) else $error("not lowest id");
    id_hold_a: assert property (!transition_launch |-> $stable(launch_id))
        else $error("launch id moved without a launch");
    shutdown_top_a: assert property (ext_trig[0] && power_state != 2'h3 |=>
        power_state == 2'h3 && launch_id == 4'h0) else $error("shutdown trigger not taken");
endmodule : rtp_ret_sva

bind rtp_retention_ctrl rtp_ret_sva #(.NTRIG(NTRIG), .NRES(NRES), .NSUB(NSUB)) u_sva (
    .aclk, .aresetn, .ext_trig, .rail_on, .rail_lp, .subsys_en, .safety_output_drive_pin,
    .gpio_retention, .ddr_retention, .power_state, .transition_launch, .launch_id
);

// [rtp_host_model.sv]
// Host software model that reaches the controller registers over AXI4-Lite
module rtp_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;

    // Response readies stay high so a task ending never collides with the next one starting
    initial begin
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p;
        logic w_p;
        aw_p = 1'b1;
        w_p = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd
endmodule : rtp_host_model

// [rtp_retention_ctrl_tb.sv]
// Self-checking bench for the retention and trigger-priority controller
module rtp_retention_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic safety_output_drive_pin, gpio_retention, ddr_retention, transition_launch;
    logic [14:0] ext_trig;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rail_on, rail_lp;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [1:0] s_axi_bresp, s_axi_rresp, power_state, rr;
    logic [3:0] s_axi_wstrb, subsys_en, launch_id;
    int failures;
    int check_count;

    rtp_retention_ctrl u_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ext_trig, .rail_on, .rail_lp, .subsys_en,
        .safety_output_drive_pin, .gpio_retention, .ddr_retention, .power_state,
        .transition_launch, .launch_id
    );
    rtp_host_model u_host (
        .aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = rtp_pkg::RESP_OKAY);
        u_host.wr(a, d, rr);
        chk("bresp", 32'(rr), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er = rtp_pkg::RESP_OKAY);
        u_host.rd(a, rv, rr);
        chk("rdata", rv, ed);
        chk("rresp", 32'(rr), 32'(er));
    endtask : rd

    // Drives the trigger levels at the next edge and stops just after the edge that takes them
    task automatic fire(input logic [14:0] t);
        @(posedge aclk);
        ext_trig <= t;
        @(posedge aclk);
        #1;
    endtask : fire

    task automatic rel();
        @(posedge aclk);
        ext_trig <= 15'h0000;
    endtask : rel

    task automatic outs(input logic [1:0] st, input logic [7:0] on, input logic [7:0] lp,
                        input logic [3:0] sub, input logic [2:0] pgd);
        chk("power_state", 32'(power_state), 32'(st));
        chk("rail_on", 32'(rail_on), 32'(on));
        chk("rail_lp", 32'(rail_lp), 32'(lp));
        chk("subsys_en", 32'(subsys_en), 32'(sub));
        chk("pin_gpio_ddr", 32'({safety_output_drive_pin, gpio_retention, ddr_retention}),
            32'(pgd));
    endtask : outs

    task automatic lnch(input logic [4:0] exp);
        chk("launch", 32'({transition_launch, launch_id}), 32'(exp));
    endtask : lnch

    task automatic wrap_up();
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        wrap_up();
    end

    initial begin
        aresetn = 1'b0;
        ext_trig = 15'h0000;
        failures = 0;
        check_count = 0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        outs(rtp_pkg::ST_STANDBY, 8'h00, 8'h00, 4'h0, 3'h0);
        rd(rtp_pkg::OFF_CTRL, rtp_pkg::CTRL_RST);
        rd(rtp_pkg::OFF_DEST_MAP, rtp_pkg::DEST_MAP_RST);
        rd(rtp_pkg::OFF_RET_MASK, rtp_pkg::RET_MASK_RST);
        rd(rtp_pkg::OFF_LP_MASK, rtp_pkg::LP_MASK_RST);
        rd(rtp_pkg::OFF_LINK_MAP, rtp_pkg::LINK_MAP_RST);
        rd(8'h18, 32'h0000_0000, rtp_pkg::RESP_SLVERR);
        wr(8'h18, 32'hFFFF_FFFF, rtp_pkg::RESP_SLVERR);
        wr(rtp_pkg::OFF_STATUS, 32'hFFFF_FFFF);
        rd(rtp_pkg::OFF_STATUS, 32'h0000_0000);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0001);
        rd(rtp_pkg::OFF_CTRL, 32'h0000_0000);
        fire(15'h0010);
        lnch(5'h14);
        outs(rtp_pkg::ST_ACTIVE, 8'hFF, 8'h00, 4'hF, 3'h0);
        @(posedge aclk);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0021);
        wr(rtp_pkg::OFF_LP_MASK, 32'h0000_0002);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0029);
        repeat (3) @(posedge aclk);
        lnch(5'h04);
        outs(rtp_pkg::ST_ACTIVE, 8'hFF, 8'h00, 4'hF, 3'h4);
        rel();
        @(posedge aclk);
        #1;
        lnch(5'h1F);
        outs(rtp_pkg::ST_RETENTION, 8'h01, 8'h02, 4'h1, 3'h2);
        @(posedge aclk);
        rd(rtp_pkg::OFF_CTRL, 32'h0000_0028);
        fire(15'h0010);
        outs(rtp_pkg::ST_ACTIVE, 8'hFF, 8'h00, 4'hF, 3'h0);
        @(posedge aclk);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0088);
        wr(rtp_pkg::OFF_LP_MASK, 32'h0000_0003);
        rel();
        @(posedge aclk);
        #1;
        outs(rtp_pkg::ST_RETENTION, 8'h00, 8'h03, 4'h0, 3'h1);
        // A request-bit write after entry must leave the variant alone
        @(posedge aclk);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_00A8);
        outs(rtp_pkg::ST_RETENTION, 8'h00, 8'h03, 4'h0, 3'h1);
        fire(15'h0011);
        lnch(5'h10);
        outs(rtp_pkg::ST_SAFE, 8'h00, 8'h00, 4'h0, 3'h0);
        @(posedge aclk);
        wr(rtp_pkg::OFF_CTRL, 32'h0000_0000);
        rel();
        fire(15'h0010);
        @(posedge aclk);
        wr(rtp_pkg::OFF_DEST_MAP, 32'h9555_51FF);
        fire(15'h0020);
        lnch(5'h15);
        outs(rtp_pkg::ST_STANDBY, 8'h00, 8'h00, 4'h0, 3'h0);
        @(posedge aclk);
        rd(rtp_pkg::OFF_STATUS, 32'h0000_0500);
        wrap_up();
    end
endmodule : rtp_retention_ctrl_tb
